/* hw/res_rail_sequencer.v */
// Functional notes
// - Release power good within longest soft-start plus step delays plus 5 ms.
// - Step delay starts after the longest soft-start of that step's rails.
// - Each power-on step waits soft-start, then its delay, before advancing.
// - Programmable mode accepts host register writes except during power-on sequencing.
// - Secure mode after rail-on ignores writes to protected registers and bits.
// - Secure protection clears only with a full supply removal.
// - Mode bit resets to zero; before rail-on all writes are accepted.
// - Bus bit clear or pin fall runs power-off steps zero to two.
// - Pin disable drives power good low; pin rise reruns power-on.
// - Bus disable keeps power good released; bus enable reruns power-on.
// - After a pin fall, power good stays low despite later bus commands.
// - Clearing rail bits turns off those rails only; setting re-enables.
// - Response bit plus external low runs power-off and drives power good low.
// - After external pull-down shutdown, bus enable reruns power-on.
// - Internal fault runs power-off, drives low; bus or pin restarts, except after a fault in secure mode after rail-on.
// - Secure protection applies only after a rail-on command.
// - Buck rails turn off when the power good line is pulled low externally after release.
// - After rail-on, sequence, release power good, then update status bits.
// - Bus requests may be refused from rail-on until sequencing completes.
`include "res_regs.vh"

module res_rail_sequencer #(
    parameter TICK_CYCLES = `RES_TICK_CYC
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Pins
    input  wire       railOnPin,
    input  wire       powerOkIn,
    output reg        powerOkOut,
    output reg        powerOkOe,
    input  wire       faultIn,
    // Register port
    input  wire       regWr,
    input  wire       regRd,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWdata,
    output reg  [7:0] regRdata,
    output reg        regAck,
    output reg        regNack,
    // Buck rail enables {a, b, c}
    output reg  [2:0] railEn
);

    localparam [4:0] S_OFF    = 5'b00001;
    localparam [4:0] S_ON_SS  = 5'b00010;
    localparam [4:0] S_ON_DLY = 5'b00100;
    localparam [4:0] S_ON     = 5'b01000;
    localparam [4:0] S_DN     = 5'b10000;

    reg [4:0] state;
    reg [1:0] stepIdx;
    reg [7:0] ctrl;
    reg [7:0] cmd;
    reg [7:0] ssCfg;
    reg [7:0] status;
    reg [7:0] onCfg  [0:2];
    reg [7:0] offCfg [0:2];
    reg [2:0] onSet;
    reg       pinS1, pinS2, pinS3, pgS1, pgS2;
    reg [1:0] relDly;
    reg       armed, onPend, pinHold, pgUnlock, faultLock;
    reg       tLoad;
    reg [7:0] tMs;
    wire      tExpired;

    reg [7:0] wrMask;
    reg [7:0] rdData;
    reg       busyOn, wrHit, locked, extLow, pgFault, onReq, offLow, offBus;
    reg       busOnRise, busOffFall;
    reg [7:0] newCmd;
    wire [2:0] ctrlRails = {ctrl[`RES_CTRL_RAIL_A], ctrl[`RES_CTRL_RAIL_B],
                            ctrl[`RES_CTRL_RAIL_C]};

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Address falls in a secure write protected range
    function isProt;
        input [7:0] a;
        begin
            isProt = (a >= `RES_PROT_HOST_LO && a <= `RES_PROT_HOST_HI) ||
                     (a == `RES_OFF_CMD) ||
                     (a >= `RES_PROT_VEND_LO && a <= `RES_PROT_VEND_HI);
        end
    endfunction

    // Longest soft-start in ms among rails of a step
    function [7:0] maxSs;
        input [2:0] m;
        input [7:0] ss;
        reg   [7:0] r;
        begin
            r = 8'h00;
            if (m[2] && {6'h00, ss[1:0]} + 8'h01 > r) r = {6'h00, ss[1:0]} + 8'h01;
            if (m[1] && {6'h00, ss[3:2]} + 8'h01 > r) r = {6'h00, ss[3:2]} + 8'h01;
            if (m[0] && {6'h00, ss[5:4]} + 8'h01 > r) r = {6'h00, ss[5:4]} + 8'h01;
            maxSs = r;
        end
    endfunction

    // ------------------------------------------------------------
    // Step timer
    // ------------------------------------------------------------
    res_step_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) uTimer (
        .clk     (clk),
        .rst     (rst),
        .load    (tLoad),
        .loadMs  (tMs),
        .expired (tExpired)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pinS1  <= 1'b0;
            pinS2  <= 1'b0;
            pinS3  <= 1'b0;
            pgS1   <= 1'b1;
            pgS2   <= 1'b1;
            relDly <= 2'b00;
        end else begin
            pinS1  <= railOnPin;
            pinS2  <= pinS1;
            pinS3  <= pinS2;
            pgS1   <= powerOkIn;
            pgS2   <= pgS1;
            relDly <= {relDly[0], ~powerOkOe};   // Settle after release
        end
    end

    // ------------------------------------------------------------
    // Request decode and write protection
    // ------------------------------------------------------------
    always @* begin
        busyOn  = (state == S_ON_SS) || (state == S_ON_DLY);
        wrHit   = regWr & ~busyOn;
        locked  = armed & ~ctrl[`RES_CTRL_MODE];
        wrMask  = 8'hFF;
        if (locked && isProt(regAddr)) begin
            if (regAddr == `RES_OFF_CMD)
                wrMask = `RES_CMD_FREE_MASK | (pgUnlock ? `RES_CMD_ON_MASK : 8'h00);
            else
                wrMask = 8'h00;
        end
        newCmd     = (cmd & ~wrMask) | (regWdata & wrMask);
        busOnRise  = wrHit && regAddr == `RES_OFF_CMD &&
                     !cmd[`RES_CMD_ON] && newCmd[`RES_CMD_ON];
        busOffFall = wrHit && regAddr == `RES_OFF_CMD &&
                     cmd[`RES_CMD_ON] && !newCmd[`RES_CMD_ON];
        extLow  = ~pgS2 & relDly[1] & ~powerOkOe;
        pgFault = extLow & cmd[`RES_CMD_PGIN];
        onReq   = (pinS2 & ~pinS3 | busOnRise) & ~faultLock;
        offLow  = (~pinS2 & pinS3) | pgFault | faultIn;
        offBus  = busOffFall & ctrl[`RES_CTRL_MODE];
    end

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    always @* begin
        case (regAddr)
            `RES_OFF_STAT:     rdData = status;
            `RES_OFF_CTRL:     rdData = ctrl;
            `RES_OFF_CMD:      rdData = cmd;
            `RES_OFF_ON0:      rdData = onCfg[0];
            `RES_OFF_ON0 + 1:  rdData = onCfg[1];
            `RES_OFF_ON2:      rdData = onCfg[2];
            `RES_OFF_SS:       rdData = ssCfg;
            `RES_OFF_OFF0:     rdData = offCfg[0];
            `RES_OFF_OFF0 + 1: rdData = offCfg[1];
            `RES_OFF_OFF2:     rdData = offCfg[2];
            default:           rdData = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Register file and bus answers
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl      <= `RES_CTRL_RST;
            cmd       <= `RES_CMD_RST;
            ssCfg     <= `RES_SS_RST;
            onCfg[0]  <= `RES_ON0_RST;
            onCfg[1]  <= `RES_ON1_RST;
            onCfg[2]  <= `RES_ON2_RST;
            offCfg[0] <= `RES_OFF0_RST;
            offCfg[1] <= `RES_OFF1_RST;
            offCfg[2] <= `RES_OFF2_RST;
            regRdata  <= 8'h00;
            regAck    <= 1'b0;
            regNack   <= 1'b0;
        end else begin
            regAck  <= (regWr | regRd) & ~busyOn;
            regNack <= (regWr | regRd) & busyOn;
            if (regRd && !busyOn)
                regRdata <= rdData;
            if (wrHit) begin
                case (regAddr)
                    `RES_OFF_CTRL:     ctrl      <= (ctrl & ~wrMask) | (regWdata & wrMask);
                    `RES_OFF_CMD:      cmd       <= newCmd;
                    `RES_OFF_ON0:      onCfg[0]  <= (onCfg[0] & ~wrMask) | (regWdata & wrMask);
                    `RES_OFF_ON0 + 1:  onCfg[1]  <= (onCfg[1] & ~wrMask) | (regWdata & wrMask);
                    `RES_OFF_ON2:      onCfg[2]  <= (onCfg[2] & ~wrMask) | (regWdata & wrMask);
                    `RES_OFF_SS:       ssCfg     <= (ssCfg & ~wrMask) | (regWdata & wrMask);
                    `RES_OFF_OFF0:     offCfg[0] <= (offCfg[0] & ~wrMask) | (regWdata & wrMask);
                    `RES_OFF_OFF0 + 1: offCfg[1] <= (offCfg[1] & ~wrMask) | (regWdata & wrMask);
                    `RES_OFF_OFF2:     offCfg[2] <= (offCfg[2] & ~wrMask) | (regWdata & wrMask);
                    default:           ctrl      <= ctrl;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= S_OFF;
            stepIdx    <= 2'd0;
            onSet      <= 3'b000;
            railEn     <= 3'b000;
            status     <= 8'h00;
            armed      <= 1'b0;
            onPend     <= 1'b0;
            pinHold    <= 1'b0;
            pgUnlock   <= 1'b0;
            faultLock  <= 1'b0;
            tLoad      <= 1'b0;
            tMs        <= 8'h00;
            powerOkOut <= 1'b0;
            powerOkOe  <= 1'b1;                      // Held low after supply up
        end else begin
            tLoad <= 1'b0;
            if (onReq)
                armed <= 1'b1;
            if (offLow)
                powerOkOe <= 1'b1;
            if (~pinS2 & pinS3)
                pinHold <= 1'b1;
            else if (pinS2 & ~pinS3)
                pinHold <= 1'b0;
            if (pgFault && locked)
                pgUnlock <= 1'b1;
            else if (busOnRise)
                pgUnlock <= 1'b0;
            if (faultIn && locked)
                faultLock <= 1'b1;                   // Cleared by supply removal
            if (onReq)
                onPend <= 1'b1;
            case (state)
                S_OFF: begin
                    if (onPend && !faultLock) begin
                        onPend  <= 1'b0;
                        stepIdx <= 2'd0;
                        onSet   <= onCfg[0][7:5] & ctrlRails;
                        railEn  <= onCfg[0][7:5] & ctrlRails;
                        tMs     <= maxSs(onCfg[0][7:5], ssCfg);
                        tLoad   <= 1'b1;
                        state   <= S_ON_SS;
                    end
                end
                S_ON_SS, S_ON_DLY: begin
                    if (offLow || offBus) begin
                        onPend  <= onReq;
                        stepIdx <= 2'd0;
                        railEn  <= railEn & ~offCfg[0][7:5];
                        tMs     <= {5'h00, offCfg[0][2:0]};
                        tLoad   <= 1'b1;
                        status  <= 8'h00;
                        state   <= S_DN;
                    end else if (tExpired && state == S_ON_SS) begin
                        tMs   <= {5'h00, onCfg[stepIdx][2:0]};
                        tLoad <= 1'b1;
                        state <= S_ON_DLY;
                    end else if (tExpired && stepIdx == 2'd2) begin
                        if (!pinHold)
                            powerOkOe <= 1'b0;
                        state <= S_ON;
                    end else if (tExpired) begin
                        stepIdx <= stepIdx + 2'd1;
                        onSet   <= onSet | (onCfg[stepIdx + 2'd1][7:5] & ctrlRails);
                        railEn  <= railEn | (onCfg[stepIdx + 2'd1][7:5] & ctrlRails);
                        tMs     <= maxSs(onCfg[stepIdx + 2'd1][7:5], ssCfg);
                        tLoad   <= 1'b1;
                        state   <= S_ON_SS;
                    end
                end
                S_ON: begin
                    railEn <= onSet & ctrlRails & {3{~extLow}};
                    status <= {2'b00, railEn[2], 1'b0, railEn[1], railEn[0], 2'b00};
                    if (offLow || offBus) begin
                        onPend  <= onReq;
                        stepIdx <= 2'd0;
                        railEn  <= railEn & ~offCfg[0][7:5];
                        tMs     <= {5'h00, offCfg[0][2:0]};
                        tLoad   <= 1'b1;
                        status  <= 8'h00;
                        state   <= S_DN;
                    end
                end
                S_DN: begin
                    if (tExpired && stepIdx == 2'd2) begin
                        railEn <= 3'b000;
                        state  <= S_OFF;
                    end else if (tExpired) begin
                        stepIdx <= stepIdx + 2'd1;
                        railEn  <= railEn & ~offCfg[stepIdx + 2'd1][7:5];
                        tMs     <= {5'h00, offCfg[stepIdx + 2'd1][2:0]};
                        tLoad   <= 1'b1;
                    end
                end
                default: begin
                    railEn <= 3'b000;
                    state  <= S_OFF;
                end
            endcase
        end
    end

endmodule // res_rail_sequencer

/* hw/res_step_timer.v */
`include "res_regs.vh"

module res_step_timer #(
    parameter TICK_CYCLES = `RES_TICK_CYC
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Load and expiry
    input  wire       load,
    input  wire [7:0] loadMs,
    output reg        expired
);

    reg [31:0] divCnt;
    reg [7:0]  msLeft;
    reg        armed;

    // ------------------------------------------------------------
    // Millisecond divider and step countdown
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            divCnt  <= 32'h0;
            msLeft  <= 8'h00;
            armed   <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (load) begin
                divCnt <= 32'h0;       // Restart time base
                msLeft <= loadMs;
                armed  <= 1'b1;
            end else if (armed) begin
                if (msLeft == 8'h00) begin
                    armed   <= 1'b0;
                    expired <= 1'b1;
                end else if (divCnt == TICK_CYCLES - 1) begin
                    divCnt <= 32'h0;
                    msLeft <= msLeft - 8'h01;
                end else begin
                    divCnt <= divCnt + 32'h1;
                end
            end
        end
    end

endmodule // res_step_timer

/* pkg/res_regs.vh */
`ifndef RES_REGS_VH
`define RES_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RES_OFF_STAT      8'h08
`define RES_OFF_CTRL      8'h2F
`define RES_OFF_CMD       8'h32
`define RES_OFF_ON0       8'h40
`define RES_OFF_ON2       8'h42
`define RES_OFF_SS        8'h43
`define RES_OFF_OFF0      8'h58
`define RES_OFF_OFF2      8'h5A

// ----------------------------------------------------------------
// Write protected ranges in secure mode
// ----------------------------------------------------------------
`define RES_PROT_HOST_LO  8'h15
`define RES_PROT_HOST_HI  8'h2F
`define RES_PROT_VEND_LO  8'h40
`define RES_PROT_VEND_HI  8'h6F
`define RES_CMD_FREE_MASK 8'h40
`define RES_CMD_ON_MASK   8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RES_CTRL_RAIL_A   6
`define RES_CTRL_RAIL_B   4
`define RES_CTRL_RAIL_C   3
`define RES_CTRL_MODE     2
`define RES_CMD_ON        7
`define RES_CMD_PGIN      5
`define RES_STAT_RAIL_A   5
`define RES_STAT_RAIL_B   3
`define RES_STAT_RAIL_C   2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RES_CTRL_RST      8'h58
`define RES_CMD_RST       8'h00
`define RES_ON0_RST       8'h80
`define RES_ON1_RST       8'h40
`define RES_ON2_RST       8'h20
`define RES_SS_RST        8'h00
`define RES_OFF0_RST      8'h20
`define RES_OFF1_RST      8'h40
`define RES_OFF2_RST      8'h80

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RES_CLK_NS        20
`define RES_TICK_NS       1000000
`define RES_TICK_CYC      (`RES_TICK_NS / `RES_CLK_NS)
`define RES_MARGIN_MS     5

`endif

/* tb/res_host_link.sv */
module res_host_link (
    // Host intent
    input  wire logic pinReq,
    input  wire logic pullReq,
    // Device side
    input  wire logic powerOkOe,
    output wire logic railOnPin,
    output wire logic powerOkIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Enable pin follows the host, never floats
    assign railOnPin = pinReq;
    // Open-drain line with pull-up, low if either side pulls
    assign powerOkIn = ~(powerOkOe | pullReq);
endmodule // res_host_link

/* tb/res_rail_sequencer_bench.sv */
module res_rail_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;
    logic       clk = 1'h0, rst = 1'h1, pinReq = 1'h0, pullReq = 1'h0, faultIn = 1'h0;
    logic       regWr = 1'h0, regRd = 1'h0, ok, nk, watchPg = 1'h0, pgDrop = 1'h0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, rd;
    wire        railOnPin, powerOkIn, powerOkOut, powerOkOe, regAck, regNack;
    wire  [7:0] regRdata;
    wire  [2:0] railEn;
    int         miscompares = 0, testsRun = 0, cycles = 0;
    // -------------------------------------------------------------
    // Design, host side and clock
    // -------------------------------------------------------------
    res_rail_sequencer #(.TICK_CYCLES(TICK)) uut (
        .clk(clk), .rst(rst), .railOnPin(railOnPin), .powerOkIn(powerOkIn),
        .powerOkOut(powerOkOut), .powerOkOe(powerOkOe), .faultIn(faultIn),
        .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regAck(regAck), .regNack(regNack), .railEn(railEn)
    );
    res_host_link uHost (
        .pinReq(pinReq), .pullReq(pullReq), .powerOkOe(powerOkOe),
        .railOnPin(railOnPin), .powerOkIn(powerOkIn)
    );
    always #10 clk = ~clk;
    // Hang guard and power good drop monitor
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            endSim;
        end
    end
    always @(negedge clk) if (watchPg && powerOkOe !== 1'h0) pgDrop = 1'h1;
    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task automatic endSim;
        if (miscompares == 0 && testsRun > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One register access, answer taken one edge after the request
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regWr <= wr;
        regRd <= !wr;
        regAddr <= a;
        regWdata <= d;
        @(negedge clk);
        regWr <= 1'h0;
        regRd <= 1'h0;
        ok = regAck;
        nk = regNack;
        rd = regRdata;
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        acc(1'h1, a, d);
        check({7'h0, ok}, 8'h01, "write ack");
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        acc(1'h0, a, 8'h00);
        check({7'h0, ok}, 8'h01, "read ack");
        check(rd, exp, "read data");
    endtask
    // Wait for {powerOkOe, railEn} under mask, bounded
    task automatic waitSt(input logic [3:0] e, input logic [3:0] m, input int lim);
        int n;
        n = 0;
        while ((({powerOkOe, railEn} & m) !== e) && n < lim) begin
            @(negedge clk);
            n++;
        end
        check({4'h0, {powerOkOe, railEn} & m}, {4'h0, e}, "pin state");
    endtask
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
        check({4'h0, powerOkOe, railEn}, 8'h08, "reset pins");
        rdChk(8'h2F, 8'h58);
        rdChk(8'h32, 8'h00);
        rdChk(8'h5A, 8'h80);
        wrReg(8'h01, 8'hFF);
        rdChk(8'h01, 8'h00);
        wrReg(8'h2F, 8'h5C);
        wrReg(8'h40, 8'h82);
        wrReg(8'h58, 8'h21);
        wrReg(8'h59, 8'h42);
        wrReg(8'h32, 8'h80);
        repeat (4) @(negedge clk);
        acc(1'h0, 8'h2F, 8'h00);
        check({7'h0, nk}, 8'h01, "nack");
        waitSt(4'h7, 4'hF, 10 * TICK - 6);
        rdChk(8'h08, 8'h2C);
        wrReg(8'h2F, 8'h4C);
        waitSt(4'h5, 4'hF, 3);
        wrReg(8'h2F, 8'h5C);
        waitSt(4'h7, 4'hF, 3);
        watchPg = 1'h1;
        wrReg(8'h32, 8'h00);
        waitSt(4'h6, 4'hF, 2 * TICK);
        waitSt(4'h4, 4'hF, 3 * TICK);
        waitSt(4'h0, 4'hF, 4 * TICK);
        wrReg(8'h32, 8'h80);
        waitSt(4'h7, 4'hF, 10 * TICK);
        // Line kept released through bus disable and re-enable; watch that it stays released
        repeat (12) @(negedge clk);
        watchPg = 1'h0;
        check({7'h0, pgDrop}, 8'h00, "pg dropped");
        wrReg(8'h32, 8'hA0);
        pullReq = 1'h1;
        waitSt(4'h8, 4'hF, 20 * TICK);
        pullReq = 1'h0;
        rdChk(8'h2F, 8'h5C);
        wrReg(8'h32, 8'h20);
        wrReg(8'h32, 8'hA0);
        waitSt(4'h7, 4'hF, 10 * TICK);
        faultIn = 1'h1;
        @(negedge clk);
        faultIn = 1'h0;
        waitSt(4'h8, 4'hF, 20 * TICK);
        wrReg(8'h32, 8'h20);
        pinReq = 1'h1;
        waitSt(4'h7, 4'hF, 10 * TICK + 4);
        pinReq = 1'h0;
        waitSt(4'h8, 4'hF, 20 * TICK);
        pinReq = 1'h1;
        waitSt(4'h7, 4'hF, 10 * TICK + 4);
        pinReq = 1'h0;
        waitSt(4'h8, 4'hF, 20 * TICK);
        wrReg(8'h32, 8'h80);
        repeat (50) @(negedge clk);
        check({7'h0, powerOkOe}, 8'h01, "pg held low");
        rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
        rdChk(8'h2F, 8'h58);
        wrReg(8'h40, 8'h81);
        rdChk(8'h40, 8'h81);
        pinReq = 1'h1;
        waitSt(4'h7, 4'hF, 9 * TICK + 4);
        wrReg(8'h2F, 8'h00);
        rdChk(8'h2F, 8'h58);
        wrReg(8'h32, 8'hFF);
        rdChk(8'h32, 8'h40);
        wrReg(8'h5A, 8'h00);
        rdChk(8'h5A, 8'h80);
        waitSt(4'h7, 4'hF, 1);
        pullReq = 1'h1;
        waitSt(4'h0, 4'h7, 2 * TICK);
        pullReq = 1'h0;
        pinReq = 1'h0;
        rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
        wrReg(8'h2F, 8'h5C);
        rdChk(8'h2F, 8'h5C);
        endSim;
    end
endmodule // res_rail_sequencer_bench

/* tb/res_rail_sequencer_properties.sv */
module res_rail_sequencer_properties #(
    parameter int TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Pins
    input wire logic       railOnPin,
    input wire logic       powerOkIn,
    input wire logic       powerOkOut,
    input wire logic       powerOkOe,
    input wire logic       faultIn,
    // Register port
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic       regAck,
    input wire logic       regNack,
    // Rails
    input wire logic [2:0] railEn
);
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------------------
    // Helper logic
    // -------------------------------------------------------------
    localparam int PG_BOUND = 40 * TICK_CYCLES;
    int unsigned onCnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles with rails up while power good is held low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) onCnt <= 0;
        else if (railEn != 3'h0 && powerOkOe) onCnt <= onCnt + 1;
        else onCnt <= 0;
    end
    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    AST_RESET_STATE: assert property ($fell(rst) |-> railEn == 3'h0 && powerOkOe && !regAck)
        else $error("outputs not in reset state after reset");
    AST_ANSWER_ONCE: assert property ((regWr || regRd) |=> regAck != regNack)
        else $error("request without exactly one answer");
    AST_ANSWER_CAUSED: assert property (!(regWr || regRd) |=> !(regAck || regNack))
        else $error("answer without request");
    AST_LINE_OPEN_DRAIN: assert property (powerOkOut == 1'h0)
        else $error("power good data not zero");
    AST_EXT_LOW_OFF: assert property ($fell(powerOkIn) && !powerOkOe && railEn != 3'h0
        |-> ##[1:200] railEn == 3'h0)
        else $error("rails stay on with line pulled low");
    AST_RELEASE_WITH_RAILS: assert property ($fell(powerOkOe) |-> railEn != 3'h0)
        else $error("power good released with no rail on");
    AST_PIN_SYNC: assert property ($changed(railOnPin) |=> $stable(railEn) [*2])
        else $error("pin acted on before synchroniser");
    AST_FAULT_OFF: assert property (faultIn && railEn != 3'h0 |-> ##[1:200] railEn == 3'h0)
        else $error("fault did not turn rails off");
    AST_PG_BOUND: assert property (onCnt <= PG_BOUND)
        else $error("power good release too late");
    // Main scenarios
    cover property ($fell(powerOkOe));
    cover property (regNack);
    cover property ($fell(powerOkIn) && !powerOkOe);
endmodule // res_rail_sequencer_properties

bind res_rail_sequencer res_rail_sequencer_properties #(
    .TICK_CYCLES(TICK_CYCLES)
) uProps (
    .clk       (clk),
    .rst       (rst),
    .railOnPin (railOnPin),
    .powerOkIn (powerOkIn),
    .powerOkOut(powerOkOut),
    .powerOkOe (powerOkOe),
    .faultIn   (faultIn),
    .regWr     (regWr),
    .regRd     (regRd),
    .regAck    (regAck),
    .regNack   (regNack),
    .railEn    (railEn)
);
